// File: rtl/ppm_pkg.sv
// Package with constants and types for the port pin override mux
package ppm_pkg;
  localparam int PPM_PINS = 8;
  localparam int PPM_AW = 12;
  localparam logic [PPM_AW-1:0] PPM_OFF_DIR = 12'h000;
  localparam logic [PPM_AW-1:0] PPM_OFF_OUT = 12'h004;
  localparam logic [PPM_AW-1:0] PPM_OFF_IN = 12'h008;
  localparam logic [PPM_AW-1:0] PPM_OFF_CTRL = 12'h00C;
  localparam logic [PPM_AW-1:0] PPM_OFF_SLEEP = 12'h010;
  localparam int PPM_CTRL_PUD_BIT = 0;
  localparam int PPM_SLEEP_EN_BIT = 0;
  localparam logic [PPM_PINS-1:0] PPM_BYTE_ZERO = 8'h00;
  localparam logic [31:0] PPM_WORD_ZERO = 32'h0000_0000;
  localparam logic [2:0] PPM_PU_PATTERN = 3'h2;
  typedef enum logic [1:0] {PPM_SM_IDLE, PPM_SM_SLEEP, PPM_SM_WAKE} ppm_sleep_t;
endpackage

// File: rtl/ppm_pin_sync.sv
// Per-pin input latch and capture stage feeding the input-value register
`timescale 1ns/10ps
module ppm_pin_sync
  import ppm_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  input wire logic [ppm_pkg::PPM_PINS-1:0] d_in,
  output logic [ppm_pkg::PPM_PINS-1:0] q_out
);
  // Latch stage modelled as first flop; only the second flop reads it
  logic [PPM_PINS-1:0] stage1_reg;
  logic [PPM_PINS-1:0] stage2_reg;

  always_ff @(posedge core_clk_in)
  begin
    if (!rst_n_in)
    begin
      stage1_reg <= PPM_BYTE_ZERO;
      stage2_reg <= PPM_BYTE_ZERO;
    end
    else
    begin
      stage1_reg <= d_in;
      stage2_reg <= stage1_reg;
    end
  end

  assign q_out = stage2_reg;
endmodule

// File: rtl/ppm_port.sv
// One eight-pin port with peripheral override mux and APB registers
//
// How it works
// RULE1: Sleep states clamp digital input to ground
// RULE2: Enabled external interrupt pins skip the clamp
// RULE3: Disabled edge interrupt high sets flag on wake
// RULE4: Pull-ups forced off while reset asserted
// RULE5: No override: pull-up when pattern 010
// RULE6: Override: pull-up follows override value only
// RULE7: Direction override value controls driver enable
// RULE8: No override: driver follows direction bit
// RULE9: Value override drives override value
// RULE10: No value override drives output bit
// RULE11: Toggle override inverts output bit
// RULE12: Input enable override forces input enable
// RULE13: No override: input enable from sleep state
// RULE14: Alternate input tapped before the synchronizer
// RULE15: Analog path connects straight to pad
// RULE16: Strobes per port, sleep and disable global
// RULE17: Peripherals generate their own override signals
// RULE18: Direction set means output, clear input
// RULE19: Global pull-up disable kills all pull-ups; here pins under pull-up override still follow the override value
// RULE20: Writing one to input register toggles output
// RULE21: Pad value latched then captured in register
// RULE22: Reset clears direction, output and override state; here override inputs are not cleared, pad_oe_out is forced off
//
// The implementer's own choices: the APB interface to the registers and the address map.
`timescale 1ns/10ps
module ppm_port
  import ppm_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [ppm_pkg::PPM_AW-1:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic global_pullup_disable_in,
  input wire logic sleep_clamp_in,
  input wire logic [ppm_pkg::PPM_PINS-1:0] pullup_ovr_en_in,
  input wire logic [ppm_pkg::PPM_PINS-1:0] pullup_ovr_val_in,
  input wire logic [ppm_pkg::PPM_PINS-1:0] dir_ovr_en_in,
  input wire logic [ppm_pkg::PPM_PINS-1:0] dir_ovr_val_in,
  input wire logic [ppm_pkg::PPM_PINS-1:0] outval_ovr_en_in,
  input wire logic [ppm_pkg::PPM_PINS-1:0] outval_ovr_val_in,
  input wire logic [ppm_pkg::PPM_PINS-1:0] out_toggle_ovr_en_in,
  input wire logic [ppm_pkg::PPM_PINS-1:0] din_enable_ovr_en_in,
  input wire logic [ppm_pkg::PPM_PINS-1:0] din_enable_ovr_val_in,
  input wire logic [ppm_pkg::PPM_PINS-1:0] ext_int_enable_in,
  input wire logic [ppm_pkg::PPM_PINS-1:0] ext_int_edge_mode_in,
  output logic [ppm_pkg::PPM_PINS-1:0] ext_int_wake_set_out,
  input wire logic [ppm_pkg::PPM_PINS-1:0] pad_in,
  output logic [ppm_pkg::PPM_PINS-1:0] pad_out,
  output logic [ppm_pkg::PPM_PINS-1:0] pad_oe_out,
  output logic [ppm_pkg::PPM_PINS-1:0] pad_pullup_out,
  output logic [ppm_pkg::PPM_PINS-1:0] alt_digital_in_out,
  input wire logic [ppm_pkg::PPM_PINS-1:0] alt_analog_io_in,
  output logic [ppm_pkg::PPM_PINS-1:0] alt_analog_io_out,
  output logic [ppm_pkg::PPM_PINS-1:0] alt_analog_io_oe_out
);
  // ------------------------------------------------------------
  // Register file
  // ------------------------------------------------------------
  logic [PPM_PINS-1:0] pin_direction_bit_reg;
  logic [PPM_PINS-1:0] pin_output_bit_reg;
  logic [PPM_PINS-1:0] pin_input_value_bit;
  logic sleep_sw_reg;
  logic [PPM_PINS-1:0] drv_en;
  logic [PPM_PINS-1:0] din_en;
  logic [PPM_PINS-1:0] pad_gated;
  logic sleep_active;
  logic wr_strobe;
  logic rd_strobe;
  logic addr_ok;
  ppm_sleep_t sleep_state_reg;
  ppm_sleep_t sleep_state_next;
  logic wake_dly_reg;

  function automatic logic [PPM_PINS-1:0] ppm_mux(input logic [PPM_PINS-1:0] en,
                                                  input logic [PPM_PINS-1:0] ovr,
                                                  input logic [PPM_PINS-1:0] dflt);
    ppm_mux = (en & ovr) | (~en & dflt);
  endfunction

  // Strobes are one per port, shared by all pins
  assign wr_strobe = psel_in && penable_in && pwrite_in; // RULE16
  assign rd_strobe = psel_in && !pwrite_in;
  assign addr_ok = (paddr_in == PPM_OFF_DIR) || (paddr_in == PPM_OFF_OUT) || (paddr_in == PPM_OFF_IN)
                   || (paddr_in == PPM_OFF_CTRL) || (paddr_in == PPM_OFF_SLEEP);
  assign pready_out = 1'b1;
  assign pslverr_out = psel_in && penable_in && !addr_ok;

  always_ff @(posedge core_clk_in)
  begin
    if (!rst_n_in)
    begin
      pin_direction_bit_reg <= PPM_BYTE_ZERO; // RULE22
    end
    else if (wr_strobe && paddr_in == PPM_OFF_DIR)
    begin
      pin_direction_bit_reg <= pwdata_in[PPM_PINS-1:0];
    end
  end

  // Toggles from software and peripherals combine; a toggle on a written bit inverts the written value
  always_ff @(posedge core_clk_in)
  begin
    if (!rst_n_in)
    begin
      pin_output_bit_reg <= PPM_BYTE_ZERO; // RULE22
    end
    else
    begin
      if (wr_strobe && paddr_in == PPM_OFF_OUT)
      begin
        pin_output_bit_reg <= pwdata_in[PPM_PINS-1:0] ^ out_toggle_ovr_en_in; // RULE11
      end
      else if (wr_strobe && paddr_in == PPM_OFF_IN)
      begin
        pin_output_bit_reg <= pin_output_bit_reg ^ pwdata_in[PPM_PINS-1:0] ^ out_toggle_ovr_en_in; // RULE20
      end
      else
      begin
        pin_output_bit_reg <= pin_output_bit_reg ^ out_toggle_ovr_en_in; // RULE11
      end
    end
  end

  always_ff @(posedge core_clk_in)
  begin
    if (!rst_n_in)
    begin
      sleep_sw_reg <= 1'b0;
    end
    else if (wr_strobe && paddr_in == PPM_OFF_SLEEP)
    begin
      sleep_sw_reg <= pwdata_in[PPM_SLEEP_EN_BIT];
    end
  end

  always_ff @(posedge core_clk_in)
  begin
    if (!rst_n_in)
    begin
      prdata_out <= PPM_WORD_ZERO;
    end
    else if (rd_strobe && !penable_in)
    begin
      prdata_out <= PPM_WORD_ZERO;
      unique case (paddr_in)
        PPM_OFF_DIR: prdata_out[PPM_PINS-1:0] <= pin_direction_bit_reg;
        PPM_OFF_OUT: prdata_out[PPM_PINS-1:0] <= pin_output_bit_reg;
        PPM_OFF_IN: prdata_out[PPM_PINS-1:0] <= pin_input_value_bit;
        PPM_OFF_CTRL: prdata_out[PPM_CTRL_PUD_BIT] <= global_pullup_disable_in;
        PPM_OFF_SLEEP: prdata_out[PPM_SLEEP_EN_BIT] <= sleep_active;
        default: prdata_out <= PPM_WORD_ZERO;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Sleep tracking
  // ------------------------------------------------------------
  // Clamp comes from the global sleep controller or the local test bit
  assign sleep_active = sleep_clamp_in || sleep_sw_reg; // RULE1

  always_comb
  begin
    sleep_state_next = sleep_state_reg;
    unique case (sleep_state_reg)
      PPM_SM_IDLE: if (sleep_active) sleep_state_next = PPM_SM_SLEEP;
      PPM_SM_SLEEP: if (!sleep_active) sleep_state_next = PPM_SM_WAKE;
      PPM_SM_WAKE: sleep_state_next = sleep_active ? PPM_SM_SLEEP : PPM_SM_IDLE;
    endcase
  end

  always_ff @(posedge core_clk_in)
  begin
    if (!rst_n_in)
    begin
      sleep_state_reg <= PPM_SM_IDLE;
    end
    else
    begin
      sleep_state_reg <= sleep_state_next;
    end
  end

  // The capture stage lags the clamp release, so the flag check waits a cycle for the freed level
  always_ff @(posedge core_clk_in)
  begin
    if (!rst_n_in)
    begin
      wake_dly_reg <= 1'b0;
    end
    else
    begin
      wake_dly_reg <= (sleep_state_reg == PPM_SM_WAKE);
    end
  end

  // The clamp hid a high level; on release that edge is reported once
  always_ff @(posedge core_clk_in)
  begin
    if (!rst_n_in)
    begin
      ext_int_wake_set_out <= PPM_BYTE_ZERO;
    end
    else
    begin
      ext_int_wake_set_out <= wake_dly_reg ?
                              (pin_input_value_bit & ext_int_edge_mode_in & ~ext_int_enable_in) :
                              PPM_BYTE_ZERO; // RULE3
    end
  end

  // ------------------------------------------------------------
  // Pin mux
  // ------------------------------------------------------------
  // Pin is output when its direction bit is set, unless overridden
  assign drv_en = ppm_mux(dir_ovr_en_in, dir_ovr_val_in, pin_direction_bit_reg); // RULE7 RULE8 RULE18
  assign pad_oe_out = rst_n_in ? drv_en : PPM_BYTE_ZERO; // RULE22
  // Pad level reads low whenever drv_en is clear, so no stale drive level leaks out
  assign pad_out = ppm_mux(outval_ovr_en_in, outval_ovr_val_in, pin_output_bit_reg) & drv_en; // RULE9 RULE10

  always_comb
  begin
    for (int i = 0; i < PPM_PINS; i++)
    begin
      pad_pullup_out[i] = pullup_ovr_en_in[i] ? pullup_ovr_val_in[i] : // RULE6
                          ({pin_direction_bit_reg[i], pin_output_bit_reg[i], global_pullup_disable_in}
                           == PPM_PU_PATTERN); // RULE5 RULE19
      if (!rst_n_in)
      begin
        pad_pullup_out[i] = 1'b0; // RULE4
      end
    end
  end

  // Interrupt pins keep their input alive during sleep
  assign din_en = ppm_mux(din_enable_ovr_en_in, din_enable_ovr_val_in,
                          ~({PPM_PINS{sleep_active}} & ~ext_int_enable_in)); // RULE2 RULE12 RULE13
  assign pad_gated = pad_in & din_en; // RULE1
  // Unsynchronised tap; receivers synchronise it themselves
  assign alt_digital_in_out = pad_gated; // RULE14 RULE17
  // Analog path bypasses the digital buffers in the pad-to-core direction only
  // The pad itself carries the return direction, so the analog input port is left for wiring only
  assign alt_analog_io_out = pad_in; // RULE15
  assign alt_analog_io_oe_out = PPM_BYTE_ZERO;

  ppm_pin_sync u_sync
  (
    .core_clk_in(core_clk_in),
    .rst_n_in(rst_n_in),
    .d_in(pad_gated),
    .q_out(pin_input_value_bit) // RULE21
  );

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  // Pin mux checks skip the reset cycles, except a_pullup_reset and a_oe_reset, which check that the outputs are forced off there
  a_pullup_reset: assert property (@(posedge core_clk_in) !rst_n_in |-> pad_pullup_out == PPM_BYTE_ZERO) // RULE4
    else $error("pull-up on during reset");

  a_pullup_pud: assert property (@(posedge core_clk_in) disable iff (!rst_n_in) // RULE19
    global_pullup_disable_in |-> (pad_pullup_out & ~pullup_ovr_en_in) == PPM_BYTE_ZERO)
    else $error("pull-up on despite global disable");

  a_pullup_ovr: assert property (@(posedge core_clk_in) disable iff (!rst_n_in) // RULE6
    rst_n_in |-> (pad_pullup_out & pullup_ovr_en_in) == (pullup_ovr_val_in & pullup_ovr_en_in))
    else $error("pull-up ignores its override");

  a_drv_follow: assert property (@(posedge core_clk_in) disable iff (!rst_n_in) // RULE7
    rst_n_in |-> (pad_oe_out & dir_ovr_en_in) == (dir_ovr_val_in & dir_ovr_en_in))
    else $error("driver enable ignores its override");

  a_drv_direction: assert property (@(posedge core_clk_in) disable iff (!rst_n_in) // RULE8 RULE18
    rst_n_in |-> (pad_oe_out & ~dir_ovr_en_in) == (pin_direction_bit_reg & ~dir_ovr_en_in))
    else $error("driver enable does not follow direction");

  a_dir_write: assert property (@(posedge core_clk_in) disable iff (!rst_n_in) // RULE8
    wr_strobe && paddr_in == PPM_OFF_DIR && dir_ovr_en_in == PPM_BYTE_ZERO
    |=> pad_oe_out == $past(pwdata_in[PPM_PINS-1:0]))
    else $error("direction write not seen on driver");

  a_pad_override: assert property (@(posedge core_clk_in) disable iff (!rst_n_in) // RULE9
    (pad_out & pad_oe_out & outval_ovr_en_in) == (outval_ovr_val_in & pad_oe_out & outval_ovr_en_in))
    else $error("pad ignores value override");

  a_pad_register: assert property (@(posedge core_clk_in) disable iff (!rst_n_in) // RULE10
    (pad_out & pad_oe_out & ~outval_ovr_en_in) == (pin_output_bit_reg & pad_oe_out & ~outval_ovr_en_in))
    else $error("pad does not follow output bit");

  a_pin_toggle: assert property (@(posedge core_clk_in) disable iff (!rst_n_in) // RULE20
    wr_strobe && paddr_in == PPM_OFF_IN && out_toggle_ovr_en_in == PPM_BYTE_ZERO
    |=> pin_output_bit_reg == ($past(pin_output_bit_reg) ^ $past(pwdata_in[PPM_PINS-1:0])))
    else $error("input register write did not toggle");

  a_ovr_toggle: assert property (@(posedge core_clk_in) disable iff (!rst_n_in) // RULE11
    !wr_strobe ##0 out_toggle_ovr_en_in != PPM_BYTE_ZERO
    |=> pin_output_bit_reg == ($past(pin_output_bit_reg) ^ $past(out_toggle_ovr_en_in)))
    else $error("toggle override lost");

  a_sync_delay: assert property (@(posedge core_clk_in) disable iff (!rst_n_in) // RULE21
    rst_n_in |-> ##2 pin_input_value_bit == $past(pad_gated, 2))
    else $error("input capture delay wrong");

  a_clamp_sleep: assert property (@(posedge core_clk_in) disable iff (!rst_n_in) // RULE1 RULE2
    sleep_active |-> (alt_digital_in_out & ~ext_int_enable_in & ~din_enable_ovr_en_in) == PPM_BYTE_ZERO)
    else $error("input not clamped in sleep");

  a_din_override: assert property (@(posedge core_clk_in) disable iff (!rst_n_in) // RULE12
    (alt_digital_in_out & din_enable_ovr_en_in) == (pad_in & din_enable_ovr_val_in & din_enable_ovr_en_in))
    else $error("input enable ignores its override");

  a_alt_tap: assert property (@(posedge core_clk_in) disable iff (!rst_n_in) // RULE14
    !sleep_active && din_enable_ovr_en_in == PPM_BYTE_ZERO |-> alt_digital_in_out == pad_in)
    else $error("alternate input not taken straight from pad");

  a_oe_reset: assert property (@(posedge core_clk_in) !rst_n_in |-> pad_oe_out == PPM_BYTE_ZERO) // RULE22
    else $error("driver on during reset");

  // Wake check: clamp released, then one cycle for the freed level to reach the input register
  sequence s_clamp_release;
    sleep_state_reg == PPM_SM_SLEEP ##1 sleep_state_reg == PPM_SM_WAKE;
  endsequence
  sequence s_level_settled;
    wake_dly_reg;
  endsequence
  a_wake_flag: assert property (@(posedge core_clk_in) disable iff (!rst_n_in) // RULE3
    s_clamp_release ##1 s_level_settled
    |=> ext_int_wake_set_out == ($past(pin_input_value_bit) & $past(ext_int_edge_mode_in)
        & ~$past(ext_int_enable_in)))
    else $error("wake flag set wrong");

  a_wake_quiet: assert property (@(posedge core_clk_in) disable iff (!rst_n_in) // RULE3
    !wake_dly_reg |=> ext_int_wake_set_out == PPM_BYTE_ZERO)
    else $error("wake flag outside wake");
endmodule

// File: tb/ppm_periph_model.sv
// Peripheral model that owns the alternate functions of one port
`timescale 1ns/10ps
module ppm_periph_model
  import ppm_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  input wire logic [1:0] mode_in,
  input wire logic [ppm_pkg::PPM_PINS-1:0] alt_digital_in_in,
  output logic [ppm_pkg::PPM_PINS-1:0] pullup_ovr_en_out,
  output logic [ppm_pkg::PPM_PINS-1:0] pullup_ovr_val_out,
  output logic [ppm_pkg::PPM_PINS-1:0] dir_ovr_en_out,
  output logic [ppm_pkg::PPM_PINS-1:0] dir_ovr_val_out,
  output logic [ppm_pkg::PPM_PINS-1:0] outval_ovr_en_out,
  output logic [ppm_pkg::PPM_PINS-1:0] outval_ovr_val_out,
  output logic [ppm_pkg::PPM_PINS-1:0] out_toggle_ovr_en_out,
  output logic [ppm_pkg::PPM_PINS-1:0] din_enable_ovr_en_out,
  output logic [ppm_pkg::PPM_PINS-1:0] din_enable_ovr_val_out,
  output logic [ppm_pkg::PPM_PINS-1:0] din_sync_out
);
  logic own;
  logic [PPM_PINS-1:0] sync1_reg;
  // ----------------------------------------
  // Override generation
  // ----------------------------------------
  assign own = (mode_in == 2'h1);
  assign pullup_ovr_en_out = own ? 8'hFF : 8'h00;
  assign pullup_ovr_val_out = own ? 8'h5A : 8'h00;
  assign dir_ovr_en_out = own ? 8'hFF : 8'h00;
  assign dir_ovr_val_out = own ? 8'hF0 : 8'h00;
  assign outval_ovr_en_out = own ? 8'hFF : 8'h00;
  assign outval_ovr_val_out = own ? 8'hAA : 8'h00;
  assign out_toggle_ovr_en_out = (mode_in == 2'h2) ? 8'h01 : 8'h00;
  assign din_enable_ovr_en_out = own ? 8'h80 : 8'h00;
  assign din_enable_ovr_val_out = own ? 8'h80 : 8'h00;
  // ----------------------------------------
  // Input synchronizer
  // ----------------------------------------
  // The tap is raw pad level, so it is resynchronised here before use
  always_ff @(posedge core_clk_in)
  begin
    sync1_reg <= rst_n_in ? alt_digital_in_in : 8'h00;
    din_sync_out <= rst_n_in ? sync1_reg : 8'h00;
  end
endmodule

// File: tb/ppm_port_test.sv
// Self-checking testbench for the port pin override mux
`timescale 1ns/10ps
module ppm_port_test;
  import ppm_pkg::*;
  logic clk = 0, rst_n = 0, psel = 0, pen = 0, pwr = 0, pready, perr, err, global_pullup_disable = 0, slp = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [7:0] pu_e, pu_v, dd_e, dd_v, pv_e, pv_v, pt_e, di_e, di_v, wake, pout, poe, pull, din, aout, aoe, dsync, seen;
  logic [7:0] int_en = 8'h00, edge_m = 8'h00, pad = 8'h00;
  logic [1:0] mode = 2'h1;
  int fails = 0, n_tests = 0;
  always #2 clk = ~clk;
  ppm_port u_ppm_port (.core_clk_in(clk), .rst_n_in(rst_n), .psel_in(psel), .penable_in(pen),
    .pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
    .pslverr_out(perr), .global_pullup_disable_in(global_pullup_disable), .sleep_clamp_in(slp), .pullup_ovr_en_in(pu_e),
    .pullup_ovr_val_in(pu_v), .dir_ovr_en_in(dd_e), .dir_ovr_val_in(dd_v), .outval_ovr_en_in(pv_e),
    .outval_ovr_val_in(pv_v), .out_toggle_ovr_en_in(pt_e), .din_enable_ovr_en_in(di_e),
    .din_enable_ovr_val_in(di_v), .ext_int_enable_in(int_en), .ext_int_edge_mode_in(edge_m),
    .ext_int_wake_set_out(wake), .pad_in(pad), .pad_out(pout), .pad_oe_out(poe), .pad_pullup_out(pull),
    .alt_digital_in_out(din), .alt_analog_io_in(8'h00), .alt_analog_io_out(aout), .alt_analog_io_oe_out(aoe));
  ppm_periph_model u_ppm_periph_model (.core_clk_in(clk), .rst_n_in(rst_n), .mode_in(mode),
    .alt_digital_in_in(din), .pullup_ovr_en_out(pu_e), .pullup_ovr_val_out(pu_v), .dir_ovr_en_out(dd_e),
    .dir_ovr_val_out(dd_v), .outval_ovr_en_out(pv_e), .outval_ovr_val_out(pv_v), .out_toggle_ovr_en_out(pt_e),
    .din_enable_ovr_en_out(di_e), .din_enable_ovr_val_out(di_v), .din_sync_out(dsync));
  task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e)
    begin
      fails++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask
  // Request held until pready is seen; one idle edge keeps strobes from double assignment
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1)
      @(posedge clk);
    rd = prdata;
    err = perr;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask
  task t_gpio;
    apb(1'b1, PPM_OFF_DIR, 32'h0F);
    apb(1'b1, PPM_OFF_OUT, 32'h33);
    chk("oe", poe, 8'h0F);
    chk("pad", pout, 8'h03);
    chk("pull", pull, 8'h30);
    global_pullup_disable <= 1'b1;
    @(posedge clk);
    chk("pud", pull, 8'h00);
    global_pullup_disable <= 1'b0;
    apb(1'b0, 12'h020, 32'h0);
    chk("unmapped", err, 1'b1);
  endtask
  task t_toggle;
    apb(1'b1, PPM_OFF_IN, 32'hFF);
    apb(1'b0, PPM_OFF_OUT, 32'h0);
    chk("sw_toggle", rd, 32'hCC);
    mode <= 2'h2;
    @(posedge clk);
    mode <= 2'h0;
    apb(1'b0, PPM_OFF_OUT, 32'h0);
    chk("ovr_toggle", rd, 32'hCD);
  endtask
  task t_ovr;
    mode <= 2'h1;
    @(posedge clk);
    chk("ovr_pull", pull, 8'h5A);
    chk("ovr_oe", poe, 8'hF0);
    chk("ovr_pad", pout, 8'hA0);
    mode <= 2'h0;
  endtask
  task t_input;
    pad <= 8'hA5;
    @(posedge clk);
    chk("din", din, 8'hA5);
    chk("aio", aout, 8'hA5);
    chk("aio_oe", aoe, 8'h00);
    repeat (3) @(posedge clk);
    chk("dsync", dsync, 8'hA5);
    apb(1'b0, PPM_OFF_IN, 32'h0);
    chk("pin_in", rd, 32'hA5);
  endtask
  task t_sleep;
    int_en <= 8'h01;
    edge_m <= 8'h04;
    slp <= 1'b1;
    mode <= 2'h1;
    @(posedge clk);
    chk("clamp_ovr", din, 8'h81);
    mode <= 2'h0;
    @(posedge clk);
    chk("clamp", din, 8'h01);
    slp <= 1'b0;
    seen = 8'h00;
    repeat (6)
    begin
      @(posedge clk);
      seen = seen | wake;
    end
    chk("wake", seen, 8'h04);
  endtask
  task t_reset;
    apb(1'b1, PPM_OFF_DIR, 32'h00);
    apb(1'b1, PPM_OFF_OUT, 32'h0F);
    chk("pre_pull", pull, 8'h0F);
    rst_n <= 1'b0;
    @(posedge clk);
    chk("mid_pull", pull, 8'h00);
    chk("mid_oe", poe, 8'h00);
    @(posedge clk);
    rst_n <= 1'b1;
    apb(1'b0, PPM_OFF_OUT, 32'h0);
    chk("rst_out", rd, 32'h00);
  endtask
  task final_report;
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial
  begin
    repeat (2000) @(posedge clk);
    fails++;
    final_report;
  end
  initial
  begin
    @(posedge clk);
    chk("rst_pull", pull, 8'h00);
    chk("rst_oe", poe, 8'h00);
    @(posedge clk);
    rst_n <= 1'b1;
    mode <= 2'h0;
    t_gpio;
    t_toggle;
    t_ovr;
    t_input;
    t_sleep;
    t_reset;
    final_report;
  end
endmodule
